/* pkg/mcu_memory_defines.vh */
// Constants for the program-memory vectors, table read path and data-memory map.
// Overview of operation
// - Reset loads program counter with reset vector.
// - Enabled external edge branches when stack not full.
// - External edge selectable: falling, rising or both.
// - Timer 0 overflow branches to timer vector.
// - Table reads address program memory via table pointer.
// - Table read writes low byte to operand; only a GP RAM, accumulator or table pointer destination takes it.
// - High part to high-byte register, unused bits zero.
// - Current-page read uses current page base.
// - Last-page read uses page at word 0300H.
// - High-byte register read-only, written only by reads.
// - Table instructions take two instruction cycles.
// - Data memory 8 bits, from 00H, regions consecutive.
// - General-purpose RAM readable and writable, direct/indirect.
// - Single-bit set or clear, except protected bits.
// - Unused special-purpose addresses read 00H.
// - Protected registers ignore writes, still readable.
// - Indirect locations redirect through paired pointer.
// - Indirect location via pointer: read 00H, no write.
// - Edge field: 00 off, 01 rise, 10 fall, 11 both.
// - Full stack records request, withholds acknowledge until return.
`ifndef MCU_MEMORY_DEFINES_VH
`define MCU_MEMORY_DEFINES_VH

// ----------------------------------------------------------------------------
// Program memory vectors and pages
// ----------------------------------------------------------------------------
`define VEC_RESET 10'h000
`define VEC_EXT_INT 10'h004
`define VEC_TIMER_INT 10'h008
`define LAST_PAGE 2'h3
`define STACK_DEPTH 2'h2

// ----------------------------------------------------------------------------
// Data memory map
// ----------------------------------------------------------------------------
`define ADDR_INDIRECT_0 8'h00
`define ADDR_POINTER_0 8'h01
`define ADDR_INDIRECT_1 8'h02
`define ADDR_POINTER_1 8'h03
`define ADDR_ACCUMULATOR 8'h05
`define ADDR_PC_LOW 8'h06
`define ADDR_TABLE_POINTER 8'h07
`define ADDR_TABLE_HIGH 8'h08
`define ADDR_WATCHDOG_SELECT 8'h09
`define ADDR_STATUS 8'h0A
`define ADDR_INT_CONTROL_0 8'h0B
`define ADDR_TIMER0_COUNT 8'h0C
`define ADDR_TIMER0_CONTROL 8'h0D
`define ADDR_PORT_A_DATA 8'h10
`define ADDR_PORT_A_DIR 8'h11
`define ADDR_PORT_A_PULLUP 8'h12
`define ADDR_PORT_A_WAKEUP 8'h13
`define ADDR_SYS_CONTROL_1 8'h1B
`define ADDR_WATCHDOG_CONTROL 8'h1C
`define ADDR_EXT_RESET_CONTROL 8'h24
`define GP_RAM_START 8'h40
`define GP_RAM_WORDS 64

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define STATUS_WRITE_MASK 8'h0F
`define EDGE_SEL_HI 7
`define EDGE_SEL_LO 6
`define SYS_CONTROL_1_RESET 8'h80
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define INT_GLOBAL_BIT 0
`define INT_EXT_EN_BIT 1
`define INT_TMR_EN_BIT 2
`define INT_EXT_FLAG_BIT 4
`define INT_TMR_FLAG_BIT 5

`endif

/* verilog/mcu_memory_map.v */
// Program-memory vectors, table read path and data-memory map of the core.
`timescale 1ns/1ps
`include "mcu_memory_defines.vh"

module mcu_memory_map (
  input wire clock,
  input wire reset,
  // Core data-memory access (direct address; indirect via the pointers).
  input wire dm_read,
  input wire dm_write,
  input wire [7:0] dm_addr,
  input wire [7:0] dm_wdata,
  input wire dm_bit_op,
  input wire dm_bit_value,
  input wire [2:0] dm_bit_index,
  output reg [7:0] dm_rdata,
  // Table read instructions.
  input wire current_page_table_read,
  input wire last_page_table_read,
  input wire [7:0] table_dest_addr,
  input wire [9:0] pc_now,
  output reg [9:0] prog_addr,
  input wire [13:0] prog_data,
  output reg table_busy,
  // Status flags supplied by the core and watchdog.
  input wire [1:0] status_sys_flags,
  input wire [3:0] status_alu_flags,
  input wire status_alu_load,
  // Events and stack.
  input wire ext_int_pin,
  input wire timer0_overflow,
  input wire [1:0] stack_level,
  input wire subroutine_return,
  input wire interrupt_return,
  input wire int_taken,
  output reg int_request,
  output reg [9:0] int_vector,
  output reg pc_load,
  output reg [9:0] pc_load_value
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg [7:0] gp_ram [0:`GP_RAM_WORDS-1];
  reg [7:0] memory_pointer_0_reg;
  reg [7:0] memory_pointer_1_reg;
  reg [7:0] accumulator_reg;
  reg [7:0] table_pointer_reg;
  reg [7:0] table_high_byte_reg;
  reg [7:0] watchdog_select_reg;
  reg [7:0] status_flags_reg;
  reg [7:0] interrupt_control_0_reg;
  reg [7:0] timer0_count_reg;
  reg [7:0] timer0_control_reg;
  reg [7:0] port_a_data_reg;
  reg [7:0] port_a_direction_reg;
  reg [7:0] port_a_pullup_reg;
  reg [7:0] port_a_wakeup_reg;
  reg [7:0] system_control_1_reg;
  reg [7:0] watchdog_control_reg;
  reg [7:0] external_reset_control_reg;
  reg ext_sync1_reg;
  reg ext_sync2_reg;
  reg ext_prev_reg;
  reg table_phase_reg;
  reg table_last_reg;
  reg [7:0] table_dest_reg;
  reg reset_seen_reg;

  // Resolves an indirect location through its paired pointer.
  function [7:0] resolve;
    input [7:0] addr;
    input [7:0] mp0;
    input [7:0] mp1;
    begin
      if (addr == `ADDR_INDIRECT_0) begin
        resolve = mp0;
      end else if (addr == `ADDR_INDIRECT_1) begin
        resolve = mp1;
      end else begin
        resolve = addr;
      end
    end
  endfunction

  // True when an address names an indirect location.
  function is_indirect;
    input [7:0] addr;
    begin
      is_indirect = (addr == `ADDR_INDIRECT_0) || (addr == `ADDR_INDIRECT_1);
    end
  endfunction

  wire [7:0] eff_addr;
  wire eff_null;
  reg [7:0] read_value;
  reg [7:0] write_value;
  wire [5:0] gp_index;
  wire ext_rise;
  wire ext_fall;
  reg ext_edge;
  wire stack_full;

  assign eff_addr = resolve(dm_addr, memory_pointer_0_reg, memory_pointer_1_reg);
  // A pointer that itself names an indirect location reaches nothing.
  assign eff_null = is_indirect(dm_addr) && is_indirect(eff_addr);
  assign gp_index = eff_addr[5:0];
  assign ext_rise = ext_sync2_reg & ~ext_prev_reg;
  assign ext_fall = ~ext_sync2_reg & ext_prev_reg;
  assign stack_full = (stack_level == `STACK_DEPTH);

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  // Selects the byte at the effective address; unused locations give zero.
  always @* begin
    read_value = 8'h00;
    if (eff_null) begin
      read_value = 8'h00;
    end else if (eff_addr >= `GP_RAM_START && eff_addr < `GP_RAM_START + `GP_RAM_WORDS) begin
      read_value = gp_ram[gp_index];
    end else if (eff_addr == `ADDR_POINTER_0) begin
      read_value = memory_pointer_0_reg;
    end else if (eff_addr == `ADDR_POINTER_1) begin
      read_value = memory_pointer_1_reg;
    end else if (eff_addr == `ADDR_ACCUMULATOR) begin
      read_value = accumulator_reg;
    end else if (eff_addr == `ADDR_PC_LOW) begin
      read_value = pc_now[7:0];
    end else if (eff_addr == `ADDR_TABLE_POINTER) begin
      read_value = table_pointer_reg;
    end else if (eff_addr == `ADDR_TABLE_HIGH) begin
      read_value = table_high_byte_reg;
    end else if (eff_addr == `ADDR_WATCHDOG_SELECT) begin
      read_value = watchdog_select_reg;
    end else if (eff_addr == `ADDR_STATUS) begin
      read_value = status_flags_reg;
    end else if (eff_addr == `ADDR_INT_CONTROL_0) begin
      read_value = interrupt_control_0_reg;
    end else if (eff_addr == `ADDR_TIMER0_COUNT) begin
      read_value = timer0_count_reg;
    end else if (eff_addr == `ADDR_TIMER0_CONTROL) begin
      read_value = timer0_control_reg;
    end else if (eff_addr == `ADDR_PORT_A_DATA) begin
      read_value = port_a_data_reg;
    end else if (eff_addr == `ADDR_PORT_A_DIR) begin
      read_value = port_a_direction_reg;
    end else if (eff_addr == `ADDR_PORT_A_PULLUP) begin
      read_value = port_a_pullup_reg;
    end else if (eff_addr == `ADDR_PORT_A_WAKEUP) begin
      read_value = port_a_wakeup_reg;
    end else if (eff_addr == `ADDR_SYS_CONTROL_1) begin
      read_value = system_control_1_reg;
    end else if (eff_addr == `ADDR_WATCHDOG_CONTROL) begin
      read_value = watchdog_control_reg;
    end else if (eff_addr == `ADDR_EXT_RESET_CONTROL) begin
      read_value = external_reset_control_reg;
    end
  end

  // Forms the value to store: whole byte, or one bit set or cleared.
  always @* begin
    write_value = dm_wdata;
    if (dm_bit_op) begin
      write_value = read_value;
      write_value[dm_bit_index] = dm_bit_value;
    end
  end

  // --------------------------------------------------------------------------
  // Data memory write path
  // --------------------------------------------------------------------------
  // Stores core writes; the table destination is written in the second cycle.
  always @(posedge clock) begin
    if (table_phase_reg && table_dest_reg >= `GP_RAM_START
        && table_dest_reg < `GP_RAM_START + `GP_RAM_WORDS) begin
      gp_ram[table_dest_reg[5:0]] <= prog_data[7:0];
    end else if (dm_write && !eff_null && eff_addr >= `GP_RAM_START
        && eff_addr < `GP_RAM_START + `GP_RAM_WORDS) begin
      gp_ram[gp_index] <= write_value;
    end
  end

  // Special-purpose registers; the high-byte register and status bits 5:4 are protected.
  always @(posedge clock) begin
    if (reset) begin
      memory_pointer_0_reg <= 8'h00;
      memory_pointer_1_reg <= 8'h00;
      accumulator_reg <= 8'h00;
      table_pointer_reg <= 8'h00;
      table_high_byte_reg <= 8'h00;
      watchdog_select_reg <= 8'h00;
      status_flags_reg <= 8'h00;
      interrupt_control_0_reg <= 8'h00;
      timer0_count_reg <= 8'h00;
      timer0_control_reg <= 8'h00;
      port_a_data_reg <= 8'h00;
      port_a_direction_reg <= 8'h00;
      port_a_pullup_reg <= 8'h00;
      port_a_wakeup_reg <= 8'h00;
      system_control_1_reg <= `SYS_CONTROL_1_RESET;
      watchdog_control_reg <= 8'h00;
      external_reset_control_reg <= 8'h00;
    end else begin
      status_flags_reg[5:4] <= status_sys_flags;
      if (status_alu_load) begin
        status_flags_reg[3:0] <= status_alu_flags;
      end
      if (table_phase_reg) begin
        table_high_byte_reg <= {2'b00, prog_data[13:8]};
        if (table_dest_reg == `ADDR_ACCUMULATOR) begin
          accumulator_reg <= prog_data[7:0];
        end else if (table_dest_reg == `ADDR_TABLE_POINTER) begin
          table_pointer_reg <= prog_data[7:0];
        end
      end else if (dm_write && !eff_null) begin
        if (eff_addr == `ADDR_POINTER_0) begin
          memory_pointer_0_reg <= write_value;
        end else if (eff_addr == `ADDR_POINTER_1) begin
          memory_pointer_1_reg <= write_value;
        end else if (eff_addr == `ADDR_ACCUMULATOR) begin
          accumulator_reg <= write_value;
        end else if (eff_addr == `ADDR_TABLE_POINTER) begin
          table_pointer_reg <= write_value;
        end else if (eff_addr == `ADDR_WATCHDOG_SELECT) begin
          watchdog_select_reg <= write_value;
        end else if (eff_addr == `ADDR_STATUS) begin
          status_flags_reg[3:0] <= write_value[3:0];
        end else if (eff_addr == `ADDR_INT_CONTROL_0) begin
          interrupt_control_0_reg <= write_value;
        end else if (eff_addr == `ADDR_TIMER0_COUNT) begin
          timer0_count_reg <= write_value;
        end else if (eff_addr == `ADDR_TIMER0_CONTROL) begin
          timer0_control_reg <= write_value;
        end else if (eff_addr == `ADDR_PORT_A_DATA) begin
          port_a_data_reg <= write_value;
        end else if (eff_addr == `ADDR_PORT_A_DIR) begin
          port_a_direction_reg <= write_value;
        end else if (eff_addr == `ADDR_PORT_A_PULLUP) begin
          port_a_pullup_reg <= write_value;
        end else if (eff_addr == `ADDR_PORT_A_WAKEUP) begin
          port_a_wakeup_reg <= write_value;
        end else if (eff_addr == `ADDR_SYS_CONTROL_1) begin
          system_control_1_reg <= {write_value[7:6], 6'h00};
        end else if (eff_addr == `ADDR_WATCHDOG_CONTROL) begin
          watchdog_control_reg <= write_value;
        end else if (eff_addr == `ADDR_EXT_RESET_CONTROL) begin
          external_reset_control_reg <= write_value;
        end
      end
      // Acknowledge clears come before the event sets, so a set in the same cycle wins.
      if (int_taken && int_vector == `VEC_EXT_INT) begin
        interrupt_control_0_reg[`INT_EXT_FLAG_BIT] <= 1'b0;
      end else if (int_taken && int_vector == `VEC_TIMER_INT) begin
        interrupt_control_0_reg[`INT_TMR_FLAG_BIT] <= 1'b0;
      end
      if (ext_edge) begin
        interrupt_control_0_reg[`INT_EXT_FLAG_BIT] <= 1'b1;
      end
      if (timer0_overflow) begin
        interrupt_control_0_reg[`INT_TMR_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Table read sequencing
  // --------------------------------------------------------------------------
  // First cycle issues the address, second cycle takes the program word.
  always @(posedge clock) begin
    if (reset) begin
      table_phase_reg <= 1'b0;
      table_last_reg <= 1'b0;
      table_dest_reg <= 8'h00;
      table_busy <= 1'b0;
      prog_addr <= `VEC_RESET;
    end else begin
      table_phase_reg <= 1'b0;
      table_busy <= 1'b0;
      prog_addr <= pc_now;
      if (!table_phase_reg && (current_page_table_read || last_page_table_read)) begin
        table_phase_reg <= 1'b1;
        table_busy <= 1'b1;
        table_last_reg <= last_page_table_read;
        table_dest_reg <= resolve(table_dest_addr, memory_pointer_0_reg,
                                  memory_pointer_1_reg);
        if (last_page_table_read) begin
          prog_addr <= {`LAST_PAGE, table_pointer_reg};
        end else begin
          prog_addr <= {pc_now[9:8], table_pointer_reg};
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // External edge, vectors and reset
  // --------------------------------------------------------------------------
  // Picks the edge named by the select field.
  always @* begin
    case (system_control_1_reg[`EDGE_SEL_HI:`EDGE_SEL_LO])
      `EDGE_RISE: ext_edge = ext_rise;
      `EDGE_FALL: ext_edge = ext_fall;
      `EDGE_BOTH: ext_edge = ext_rise | ext_fall;
      default: ext_edge = 1'b0;
    endcase
  end

  // Synchronises the pin and raises the request when the stack has room.
  always @(posedge clock) begin
    if (reset) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      int_request <= 1'b0;
      int_vector <= `VEC_RESET;
      reset_seen_reg <= 1'b1;
      pc_load <= 1'b0;
      pc_load_value <= `VEC_RESET;
    end else begin
      ext_sync1_reg <= ext_int_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
      reset_seen_reg <= 1'b0;
      pc_load <= reset_seen_reg;
      pc_load_value <= `VEC_RESET;
      int_request <= 1'b0;
      // A full stack keeps the flag but withholds the request until a return.
      if (interrupt_control_0_reg[`INT_GLOBAL_BIT] && !int_taken
          && (!stack_full || subroutine_return || interrupt_return)) begin
        if (interrupt_control_0_reg[`INT_EXT_EN_BIT]
            && interrupt_control_0_reg[`INT_EXT_FLAG_BIT]) begin
          int_request <= 1'b1;
          int_vector <= `VEC_EXT_INT;
        end else if (interrupt_control_0_reg[`INT_TMR_EN_BIT]
            && interrupt_control_0_reg[`INT_TMR_FLAG_BIT]) begin
          int_request <= 1'b1;
          int_vector <= `VEC_TIMER_INT;
        end
      end
    end
  end

  // Returns read data one cycle after the read strobe.
  always @(posedge clock) begin
    if (reset) begin
      dm_rdata <= 8'h00;
    end else if (dm_read) begin
      dm_rdata <= read_value;
    end
  end

endmodule // mcu_memory_map

/* tb/mcu_program_rom.sv */
// Program memory model feeding the table read path of the memory map.
`timescale 1ns/1ps
module mcu_program_rom (
  input wire [9:0] prog_addr,
  output wire [13:0] prog_data
);
  // Each word carries its own address, so a wrong page or offset reads back differently.
  assign prog_data = {prog_addr[9:4], prog_addr[7:0] ^ 8'hA5};
endmodule // mcu_program_rom

/* tb/mcu_memory_map_chk.sv */
// Concurrent checks on the ports of the memory map block.
`timescale 1ns/1ps
module mcu_memory_map_chk (
  input logic clock,
  input logic reset,
  input logic dm_read,
  input logic [7:0] dm_addr,
  input logic [7:0] dm_rdata,
  input logic current_page_table_read,
  input logic last_page_table_read,
  input logic [9:0] pc_now,
  input logic [9:0] prog_addr,
  input logic table_busy,
  input logic [1:0] stack_level,
  input logic int_request,
  input logic [9:0] int_vector,
  input logic pc_load,
  input logic [9:0] pc_load_value
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // Table read steps, vectors, stack and read data
  // ---------------------------------------------------------------
  sequence table_start;
    (current_page_table_read || last_page_table_read) && !table_busy;
  endsequence
  sequence busy_pulse;
    table_busy ##1 !table_busy;
  endsequence
  a_reset_vector: assert property ($fell(reset) |-> ##[0:1] (pc_load && pc_load_value == 10'h000))
    else $error("reset vector not loaded");
  a_pc_once: assert property (pc_load |=> !pc_load)
    else $error("program counter load longer than one cycle");
  a_table_two_cycles: assert property (table_start |=> busy_pulse)
    else $error("table read not two cycles");
  a_current_page: assert property (current_page_table_read && !table_busy |=> prog_addr[9:8] == $past(pc_now[9:8]))
    else $error("current page table address wrong");
  a_last_page: assert property (last_page_table_read && !table_busy |=> prog_addr[9:8] == 2'h3)
    else $error("last page table address wrong");
  a_int_vector: assert property (int_request |-> (int_vector == 10'h004 || int_vector == 10'h008))
    else $error("interrupt vector wrong");
  a_stack_full: assert property (int_request |-> $past(stack_level) != 2'h2)
    else $error("request raised on full stack");
  a_rdata_hold: assert property (!$past(dm_read) && !$past(reset) |-> $stable(dm_rdata))
    else $error("read data changed without read");
  a_unused_read: assert property (dm_read && dm_addr == 8'h04 && !table_busy |=> dm_rdata == 8'h00)
    else $error("unused address read nonzero");
endmodule // mcu_memory_map_chk

bind mcu_memory_map mcu_memory_map_chk i_mcu_memory_map_chk (
  .clock(clock), .reset(reset), .dm_read(dm_read), .dm_addr(dm_addr), .dm_rdata(dm_rdata),
  .current_page_table_read(current_page_table_read), .last_page_table_read(last_page_table_read),
  .pc_now(pc_now), .prog_addr(prog_addr), .table_busy(table_busy), .stack_level(stack_level),
  .int_request(int_request), .int_vector(int_vector), .pc_load(pc_load),
  .pc_load_value(pc_load_value)
);

/* tb/test_mcu_memory_map.sv */
// Self-checking testbench for the memory map, table read and vector logic.
`timescale 1ns/1ps
`include "mcu_memory_defines.vh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %0t %s", $time, m); end end
module test_mcu_memory_map;
  logic clock = 0;
  logic reset = 1;
  logic dm_read = 0, dm_write = 0, dm_bit_op = 0, dm_bit_value = 0;
  logic [7:0] dm_addr = 0, dm_wdata = 0, table_dest_addr = 0;
  logic [2:0] dm_bit_index = 0;
  logic current_page_table_read = 0, last_page_table_read = 0;
  logic [9:0] pc_now = 0;
  logic [1:0] status_sys_flags = 2'h2, stack_level = 0;
  logic ext_int_pin = 0, timer0_overflow = 0, subroutine_return = 0, int_taken = 0;
  logic interrupt_return = 0;
  wire [7:0] dm_rdata;
  wire [9:0] prog_addr, int_vector, pc_load_value;
  wire [13:0] prog_data;
  wire table_busy, int_request, pc_load;
  int err_total = 0, n_checks = 0;

  mcu_memory_map i_mcu_memory_map (.clock(clock), .reset(reset), .dm_read(dm_read),
    .dm_write(dm_write), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_bit_op(dm_bit_op),
    .dm_bit_value(dm_bit_value), .dm_bit_index(dm_bit_index), .dm_rdata(dm_rdata),
    .current_page_table_read(current_page_table_read), .table_busy(table_busy),
    .last_page_table_read(last_page_table_read), .table_dest_addr(table_dest_addr),
    .pc_now(pc_now), .prog_addr(prog_addr), .prog_data(prog_data),
    .status_sys_flags(status_sys_flags), .status_alu_flags(4'h0), .status_alu_load(1'b0),
    .ext_int_pin(ext_int_pin), .timer0_overflow(timer0_overflow), .stack_level(stack_level),
    .subroutine_return(subroutine_return), .interrupt_return(interrupt_return),
    .int_taken(int_taken),
    .int_request(int_request), .int_vector(int_vector), .pc_load(pc_load),
    .pc_load_value(pc_load_value));
  mcu_program_rom i_mcu_program_rom (.prog_addr(prog_addr), .prog_data(prog_data));

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Byte write, or single-bit write with d[2:0] the index and d[3] the value.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(posedge clock);
    dm_write <= 1;
    dm_addr <= a;
    dm_wdata <= d;
    dm_bit_op <= b;
    dm_bit_index <= d[2:0];
    dm_bit_value <= d[3];
    @(posedge clock);
    dm_write <= 0;
    dm_bit_op <= 0;
  endtask

  // Read one byte and compare it.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    dm_read <= 1;
    dm_addr <= a;
    @(posedge clock);
    dm_read <= 0;
    #1 `CHK(dm_rdata, e, "read data")
  endtask

  // Acknowledge whatever vector is offered and let the flag settle.
  task automatic take;
    @(posedge clock);
    int_taken <= 1;
    @(posedge clock);
    int_taken <= 0;
    repeat (2) @(posedge clock);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Release reset and look for the reset vector load.
  task automatic chk_reset;
    logic seen;
    seen = 0;
    repeat (3) @(posedge clock);
    reset <= 0;
    repeat (3) begin
      @(posedge clock);
      #1 if (pc_load === 1'b1 && pc_load_value === `VEC_RESET) seen = 1;
    end
    `CHK(seen, 1'b1, "reset vector load")
  endtask

  // One table read, then its destination and the read-only high byte.
  task automatic tab(input logic last, input logic [7:0] tp, input logic [9:0] pc,
                     input logic [7:0] dst);
    logic [9:0] a;
    logic [13:0] w;
    a = {(last ? 2'h3 : pc[9:8]), tp};
    w = {a[9:4], a[7:0] ^ 8'hA5};
    wr(`ADDR_TABLE_POINTER, tp, 0);
    @(posedge clock);
    current_page_table_read <= !last;
    last_page_table_read <= last;
    table_dest_addr <= dst;
    pc_now <= pc;
    @(posedge clock);
    current_page_table_read <= 0;
    last_page_table_read <= 0;
    #1 `CHK(table_busy, 1'b1, "table busy")
    `CHK(prog_addr, a, "table address")
    @(posedge clock);
    #1 `CHK(table_busy, 1'b0, "table busy end")
    rd(dst, w[7:0]);
    rd(`ADDR_TABLE_HIGH, {2'b00, w[13:8]});
    wr(`ADDR_TABLE_HIGH, 8'hFF, 0);
    rd(`ADDR_TABLE_HIGH, {2'b00, w[13:8]});
  endtask

  // Select an edge mode, move the pin, and see whether the external vector follows.
  task automatic ext(input logic [1:0] mode, input logic lvl, input logic exp);
    logic seen;
    seen = 0;
    wr(`ADDR_SYS_CONTROL_1, {mode, 6'h00}, 0);
    @(posedge clock);
    ext_int_pin <= lvl;
    repeat (8) begin
      @(posedge clock);
      #1 if (int_request === 1'b1 && !seen) begin
        seen = 1;
        `CHK(int_vector, `VEC_EXT_INT, "external vector")
      end
    end
    `CHK(seen, exp, "external request")
    take();
  endtask

  // Timer overflow on a full stack is held back until a return frees a level.
  task automatic tmr_stack(input logic iret);
    logic seen;
    seen = 0;
    wr(`ADDR_INT_CONTROL_0, 8'h05, 0);
    @(posedge clock);
    stack_level <= 2'h2;
    timer0_overflow <= 1;
    @(posedge clock);
    timer0_overflow <= 0;
    repeat (6) begin
      @(posedge clock);
      #1 if (int_request === 1'b1) seen = 1;
    end
    `CHK(seen, 1'b0, "request on full stack")
    @(posedge clock);
    stack_level <= 2'h1;
    subroutine_return <= !iret;
    interrupt_return <= iret;
    @(posedge clock);
    subroutine_return <= 0;
    interrupt_return <= 0;
    repeat (6) begin
      @(posedge clock);
      #1 if (int_request === 1'b1 && !seen) begin
        seen = 1;
        `CHK(int_vector, `VEC_TIMER_INT, "timer vector")
      end
    end
    `CHK(seen, 1'b1, "timer request after return")
    take();
  endtask

  // ---------------------------------------------------------------
  // Main sequence and verdict
  // ---------------------------------------------------------------
  task automatic summarize;
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    summarize();
  end

  // Scenarios in order.
  initial begin
    chk_reset();
    rd(8'h04, 8'h00);
    rd(8'h30, 8'h00);
    rd(`ADDR_SYS_CONTROL_1, `SYS_CONTROL_1_RESET);
    wr(`ADDR_SYS_CONTROL_1, 8'hFF, 0);
    rd(`ADDR_SYS_CONTROL_1, 8'hC0);
    wr(`ADDR_STATUS, 8'hFF, 0);
    rd(`ADDR_STATUS, 8'h2F);
    wr(8'h40, 8'h5A, 0);
    rd(8'h40, 8'h5A);
    wr(8'h7F, 8'hA5, 0);
    rd(8'h7F, 8'hA5);
    wr(8'h40, 8'h08, 1);
    rd(8'h40, 8'h5B);
    wr(8'h40, 8'h01, 1);
    rd(8'h40, 8'h59);
    wr(`ADDR_POINTER_0, 8'h41, 0);
    wr(`ADDR_INDIRECT_0, 8'h33, 0);
    rd(8'h41, 8'h33);
    wr(`ADDR_POINTER_1, 8'h42, 0);
    wr(`ADDR_INDIRECT_1, 8'h77, 0);
    rd(8'h42, 8'h77);
    wr(`ADDR_POINTER_0, `ADDR_INDIRECT_1, 0);
    rd(`ADDR_INDIRECT_0, 8'h00);
    wr(`ADDR_INDIRECT_0, 8'h55, 0);
    rd(8'h42, 8'h77);
    tab(0, 8'h06, 10'h1C0, 8'h40);
    tab(1, 8'hFF, 10'h0C0, 8'h41);
    tab(1, 8'h00, 10'h000, `ADDR_ACCUMULATOR);
    wr(`ADDR_INT_CONTROL_0, 8'h03, 0);
    ext(`EDGE_RISE, 1'b1, 1'b1);
    ext(`EDGE_RISE, 1'b0, 1'b0);
    ext(`EDGE_FALL, 1'b1, 1'b0);
    ext(`EDGE_FALL, 1'b0, 1'b1);
    ext(`EDGE_BOTH, 1'b1, 1'b1);
    ext(`EDGE_BOTH, 1'b0, 1'b1);
    ext(`EDGE_OFF, 1'b1, 1'b0);
    ext(`EDGE_OFF, 1'b0, 1'b0);
    wr(`ADDR_INT_CONTROL_0, 8'h01, 0);
    ext(`EDGE_BOTH, 1'b1, 1'b0);
    tmr_stack(1'b0);
    tmr_stack(1'b1);
    summarize();
  end
endmodule // test_mcu_memory_map
